// *** design/timer_core.sv ***
// Behaviour
// R1 - Up to two timers, index zero and one, each with own counter.
// R2 - Counter equal to comparator raises interrupt, may clear counter and change pin.
// R3 - Three-bit select picks system, high-speed, time-base or external clock.
// R4 - Reserved select code 101 gives the counter no clock.
// R5 - External pin edges advance counter as clock or event counter.
// R6 - External pin active edge is selectable rising or falling.
// R7 - Compact and standard timers have comparators A and P, each interrupting.
// R8 - Enhanced timer has comparators A, B and P: three interrupts.
// R9 - Compare output mode sets, clears or toggles pins on match.
// R10 - PWM waveform appears on the compare output pins.
// R11 - Software routes each pin to the timer with its selection bit first.
// R12 - Port data bits pick true or inverted output per pin: complementary pair.
// R13 - Selection bit one gives timer function; zero keeps other function.
// R14 - Compact period compare is three top bits; A compares all ten.
// R15 - Counter increments per active edge, wraps unless a match clears it.
//
// Timer core top: AXI4-Lite register slave, two timers, pin muxing, interrupt.
// Assumes all pins synchronous to aclk and tick strobes one aclk cycle wide.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_core #(
  parameter int    NUM_TIMERS = `TMR_NUM_TIMERS,
  parameter int    CNT_W      = `TMR_CNT_WIDTH,
  parameter logic [NUM_TIMERS-1:0] HAS_B = 2'b10
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  sys_tick,
  input  wire logic                  hs_tick,
  input  wire logic                  tbc_tick,
  input  wire logic [NUM_TIMERS-1:0] external_timer_clock_pin,
  input  wire logic [7:0]            shared_func_out,
  output logic [7:0]                 timer_output_pin_r,
  output logic [7:0]                 timer_output_en_r,
  output logic                       irq_r
);
  localparam int NEVT = 3 * NUM_TIMERS;

  timer_pkg::timer_cfg_t cfg_r [NUM_TIMERS];
  logic [CNT_W-1:0]      count  [NUM_TIMERS];
  timer_pkg::timer_evt_t evt    [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tick;
  logic [NUM_TIMERS-1:0] wave;
  logic [NUM_TIMERS-1:0] cnt_clear;
  logic [NEVT-1:0]       status_r;
  logic [NEVT-1:0]       mask_r;
  logic [NEVT-1:0]       evt_vec;
  logic [7:0]            timer_pin_function_select;
  logic [7:0]            port_data_r;

  // Address decode and write-strobe merge helpers
  function automatic logic is_timer_reg(input logic [31:0] a, input int t,
                                        input logic [31:0] off);
    is_timer_reg = (a[7:0] == 8'(`TMR_STRIDE * t + off));
  endfunction

  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    wmerge = s[0] ? d[7:0] : old;
  endfunction

  // AXI write path: address and data taken in either order
  logic        aw_have_r;
  logic        w_have_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        wr_hit;

  logic        aw_have_nxt;
  logic        w_have_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;

  assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign aw_have_nxt = (s_axi_awvalid & s_axi_awready) | (aw_have_r & ~wr_go);
  assign w_have_nxt  = (s_axi_wvalid & s_axi_wready) | (w_have_r & ~wr_go);
  assign bvalid_nxt  = wr_go | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_nxt  = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

  // Readies come from flops fed by next state; low for one cycle after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_have_nxt & ~bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_hit = (aw_addr_r[31:8] == '0) &&
             ((aw_addr_r[7:0] == 8'(`TMR_OFF_STATUS)) || (aw_addr_r[7:0] == 8'(`TMR_OFF_MASK))
              || (aw_addr_r[7:0] == 8'(`TMR_OFF_PINSEL))
              || (aw_addr_r[7:0] == 8'(`TMR_OFF_PORTDATA)));
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (aw_addr_r[31:8] == '0 && aw_addr_r[7:0] >= 8'(`TMR_STRIDE * t)
          && aw_addr_r[7:0] <= 8'(`TMR_STRIDE * t + `TMR_OFF_OUTCFG)
          && aw_addr_r[1:0] == 2'b00) begin
        wr_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TMR_AXI_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `TMR_AXI_OKAY : `TMR_AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Per-timer configuration registers
  for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_r[g]       <= '0;
        cfg_r[g].has_b <= HAS_B[g];  // see R8
      end else if (wr_go && aw_addr_r[31:8] == '0) begin
        if (is_timer_reg(aw_addr_r, g, `TMR_OFF_CTRL) && w_strb_r[0]) begin
          cfg_r[g].clk_sel   <= w_data_r[`TMR_CTRL_CKSEL_LSB +: 3];  // see R3
          cfg_r[g].fall_edge <= w_data_r[`TMR_CTRL_EDGE_BIT];  // see R6
          cfg_r[g].run       <= w_data_r[`TMR_CTRL_RUN_BIT];
          cfg_r[g].clr_on_p  <= w_data_r[`TMR_CTRL_CLRP_BIT];
          cfg_r[g].clr_on_a  <= w_data_r[`TMR_CTRL_CLRA_BIT];
        end
        if (is_timer_reg(aw_addr_r, g, `TMR_OFF_CTRL) && w_strb_r[1]) begin
          cfg_r[g].mode <= timer_pkg::timer_mode_t'(w_data_r[`TMR_CTRL_MODE_LSB +: 2]);
        end
        if (is_timer_reg(aw_addr_r, g, `TMR_OFF_CMPA)) begin
          if (w_strb_r[0]) cfg_r[g].cmp_a[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) cfg_r[g].cmp_a[9:8] <= w_data_r[9:8];
        end
        if (is_timer_reg(aw_addr_r, g, `TMR_OFF_CMPB) && HAS_B[g]) begin
          if (w_strb_r[0]) cfg_r[g].cmp_b[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) cfg_r[g].cmp_b[9:8] <= w_data_r[9:8];
        end
        if (is_timer_reg(aw_addr_r, g, `TMR_OFF_CMPP) && w_strb_r[0]) begin
          cfg_r[g].cmp_p <= w_data_r[2:0];  // see R14
        end
        if (is_timer_reg(aw_addr_r, g, `TMR_OFF_OUTCFG) && w_strb_r[0]) begin
          cfg_r[g].act_a <= timer_pkg::out_action_t'(w_data_r[1:0]);  // see R9
          cfg_r[g].act_b <= timer_pkg::out_action_t'(w_data_r[3:2]);
          cfg_r[g].act_p <= timer_pkg::out_action_t'(w_data_r[5:4]);
        end
      end
    end

    // Writing the count register restarts the counter from zero
    assign cnt_clear[g] = wr_go && aw_addr_r[31:8] == '0
                          && is_timer_reg(aw_addr_r, g, `TMR_OFF_COUNT);

    timer_tick_select u_tick (  // see R1
      .aclk      (aclk),
      .aresetn   (aresetn),
      .clk_sel   (cfg_r[g].clk_sel),
      .fall_edge (cfg_r[g].fall_edge),
      .sys_tick  (sys_tick),
      .hs_tick   (hs_tick),
      .tbc_tick  (tbc_tick),
      .ext_pin   (external_timer_clock_pin[g]),
      .tick      (tick[g])
    );

    timer_channel #(.CNT_W(CNT_W)) u_chan (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .tick      (tick[g]),
      .cnt_clear (cnt_clear[g]),
      .cfg       (cfg_r[g]),
      .count_r   (count[g]),
      .evt       (evt[g]),
      .wave_r    (wave[g])
    );

    assign evt_vec[3*g +: 3] = {evt[g].match_b, evt[g].match_p, evt[g].match_a};  // see R7
  end

  // Global registers: pin select, port data, mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_pin_function_select <= `TMR_PINSEL_RESET;
      port_data_r               <= `TMR_PORTDATA_RESET;
      mask_r                    <= '0;
    end else if (wr_go && aw_addr_r[31:8] == '0) begin
      if (aw_addr_r[7:0] == 8'(`TMR_OFF_PINSEL))
        timer_pin_function_select <= wmerge(timer_pin_function_select, w_data_r, w_strb_r);
      if (aw_addr_r[7:0] == 8'(`TMR_OFF_PORTDATA))
        port_data_r <= wmerge(port_data_r, w_data_r, w_strb_r);
      if (aw_addr_r[7:0] == 8'(`TMR_OFF_MASK) && w_strb_r[0])
        mask_r <= w_data_r[NEVT-1:0];
    end
  end

  // AXI read path; a status read clears the bits it returned
  logic        rd_status;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign rd_status = s_axi_arvalid && s_axi_arready && s_axi_araddr == `TMR_OFF_STATUS;

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b0;
    if (s_axi_araddr[31:8] == '0) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (is_timer_reg(s_axi_araddr, t, `TMR_OFF_CTRL)) begin
          rd_word = {22'd0, cfg_r[t].mode, 1'b0, cfg_r[t].clr_on_a, cfg_r[t].clr_on_p,
                     cfg_r[t].run, cfg_r[t].fall_edge, cfg_r[t].clk_sel};
          rd_ok   = 1'b1;
        end
        if (is_timer_reg(s_axi_araddr, t, `TMR_OFF_CMPA)) begin
          rd_word = {22'd0, cfg_r[t].cmp_a};
          rd_ok   = 1'b1;
        end
        if (is_timer_reg(s_axi_araddr, t, `TMR_OFF_CMPB)) begin
          rd_word = {22'd0, cfg_r[t].cmp_b};
          rd_ok   = 1'b1;
        end
        if (is_timer_reg(s_axi_araddr, t, `TMR_OFF_CMPP)) begin
          rd_word = {29'd0, cfg_r[t].cmp_p};
          rd_ok   = 1'b1;
        end
        if (is_timer_reg(s_axi_araddr, t, `TMR_OFF_COUNT)) begin
          rd_word = {{(32-CNT_W){1'b0}}, count[t]};
          rd_ok   = 1'b1;
        end
        if (is_timer_reg(s_axi_araddr, t, `TMR_OFF_OUTCFG)) begin
          rd_word = {26'd0, cfg_r[t].act_p, cfg_r[t].act_b, cfg_r[t].act_a};
          rd_ok   = 1'b1;
        end
      end
      case (s_axi_araddr[7:0])
        8'(`TMR_OFF_STATUS):   begin rd_word = {{(32-NEVT){1'b0}}, status_r}; rd_ok = 1'b1; end
        8'(`TMR_OFF_MASK):     begin rd_word = {{(32-NEVT){1'b0}}, mask_r}; rd_ok = 1'b1; end
        8'(`TMR_OFF_PINSEL):   begin rd_word = {24'd0, timer_pin_function_select}; rd_ok = 1'b1; end
        8'(`TMR_OFF_PORTDATA): begin rd_word = {24'd0, port_data_r}; rd_ok = 1'b1; end
        default:               ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `TMR_AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? `TMR_AXI_OKAY : `TMR_AXI_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sticky events: a new match wins over the read-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= (rd_status ? '0 : status_r) | evt_vec;  // see R2
      irq_r    <= |(((rd_status ? '0 : status_r) | evt_vec) & mask_r);
    end
  end

  // Pin mapping: bits 1:0 timer 0, bits 7:4 timer 1; a zero port data bit inverts  // see R12
  logic [7:0] pin_wave;
  always_comb begin
    pin_wave = '0;
    pin_wave[1:0] = {2{wave[0]}};
    if (NUM_TIMERS > 1) pin_wave[7:4] = {4{wave[NUM_TIMERS-1]}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_output_pin_r <= '0;
      timer_output_en_r  <= '1;
    end else begin
      for (int i = 0; i < 8; i++) begin
        // Software must have set the selection bit before relying on the pin  // see R11
        if (timer_pin_function_select[i]) begin  // see R13
          timer_output_pin_r[i] <= pin_wave[i] ^ ~port_data_r[i];  // see R10
          timer_output_en_r[i]  <= 1'b0;
        end else begin
          timer_output_pin_r[i] <= shared_func_out[i];
          timer_output_en_r[i]  <= 1'b1;
        end
      end
    end
  end
endmodule

// *** shared/timer_regs.svh ***
// Register offsets, field positions, reset values and encodings of the timer core.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

`define TMR_NUM_TIMERS        2
`define TMR_CNT_WIDTH         10
`define TMR_PER_WIDTH         3
`define TMR_STRIDE            32'h0000_0020
`define TMR_OFF_CTRL          32'h0000_0000
`define TMR_OFF_CMPA          32'h0000_0004
`define TMR_OFF_CMPB          32'h0000_0008
`define TMR_OFF_CMPP          32'h0000_000C
`define TMR_OFF_COUNT         32'h0000_0010
`define TMR_OFF_OUTCFG        32'h0000_0014
`define TMR_OFF_STATUS        32'h0000_0040
`define TMR_OFF_MASK          32'h0000_0044
`define TMR_OFF_PINSEL        32'h0000_0048
`define TMR_OFF_PORTDATA      32'h0000_004C
`define TMR_CTRL_CKSEL_LSB    0
`define TMR_CTRL_EDGE_BIT     3
`define TMR_CTRL_RUN_BIT      4
`define TMR_CTRL_CLRP_BIT     5
`define TMR_CTRL_CLRA_BIT     6
`define TMR_CTRL_MODE_LSB     8
`define TMR_CTRL_RESET        32'h0000_0000
`define TMR_CKSEL_SYS_DIV4    3'h0
`define TMR_CKSEL_SYS         3'h1
`define TMR_CKSEL_HS_DIV16    3'h2
`define TMR_CKSEL_HS_DIV64    3'h3
`define TMR_CKSEL_TBC         3'h4
`define TMR_CKSEL_RESERVED    3'h5
`define TMR_CKSEL_EXT_A       3'h6
`define TMR_CKSEL_EXT_B       3'h7
`define TMR_PINSEL_RESET      8'h11
`define TMR_PORTDATA_RESET    8'hFF
`define TMR_AXI_OKAY          2'h0
`define TMR_AXI_SLVERR        2'h2

`endif

// *** shared/timer_pkg.sv ***
// Types shared by the timer core files.
// Assumes timer_regs.svh is compiled alongside.
package timer_pkg;

  typedef enum logic [1:0] {
    OUT_HOLD   = 2'h0,
    OUT_LOW    = 2'h1,
    OUT_HIGH   = 2'h2,
    OUT_TOGGLE = 2'h3
  } out_action_t;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_TIMER   = 2'h1,
    MODE_PWM     = 2'h2
  } timer_mode_t;

  typedef struct packed {
    logic [2:0]  clk_sel;
    logic        fall_edge;
    logic        run;
    logic        clr_on_p;
    logic        clr_on_a;
    timer_mode_t mode;
    out_action_t act_a;
    out_action_t act_b;
    out_action_t act_p;
    logic [9:0]  cmp_a;
    logic [9:0]  cmp_b;
    logic [2:0]  cmp_p;
    logic        has_b;
  } timer_cfg_t;

  typedef struct packed {
    logic match_a;
    logic match_b;
    logic match_p;
  } timer_evt_t;

endpackage

// *** design/timer_tick_select.sv ***
// Chooses one count tick per timer from prescaled internal clocks or the external pin.
// Assumes the external pin is already synchronous to aclk.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_tick_select (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] clk_sel,
  input  wire logic       fall_edge,
  input  wire logic       sys_tick,
  input  wire logic       hs_tick,
  input  wire logic       tbc_tick,
  input  wire logic       ext_pin,
  output logic            tick
);
  logic [5:0] div_r;
  logic       ext_prev_r;
  logic       ext_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r      <= '0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_pin;
      if (hs_tick) begin
        div_r <= div_r + 6'd1;
      end
    end
  end

  // Either edge polarity is usable for counting events     // see R6
  assign ext_edge = fall_edge ? (ext_prev_r & ~ext_pin) : (~ext_prev_r & ext_pin);

  always_comb begin
    case (clk_sel)  // see R3
      `TMR_CKSEL_SYS_DIV4: tick = sys_tick & (div_r[1:0] == 2'd3);
      `TMR_CKSEL_SYS:      tick = sys_tick;
      `TMR_CKSEL_HS_DIV16: tick = hs_tick & (div_r[3:0] == 4'hF);
      `TMR_CKSEL_HS_DIV64: tick = hs_tick & (div_r == 6'h3F);
      `TMR_CKSEL_TBC:      tick = tbc_tick;
      `TMR_CKSEL_RESERVED: tick = 1'b0;  // see R4
      default:             tick = ext_edge;  // see R5
    endcase
  end
endmodule

// *** design/timer_channel.sv ***
// One timer: 10-bit counter, compare A/B/P, output action logic.
// Assumes a one-cycle count tick and the configuration held by the top.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_channel #(
  parameter int CNT_W = `TMR_CNT_WIDTH
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                tick,
  input  wire logic                cnt_clear,
  input  timer_pkg::timer_cfg_t    cfg,
  output logic [CNT_W-1:0]         count_r,
  output timer_pkg::timer_evt_t    evt,
  output logic                     wave_r
);
  logic hit_a;
  logic hit_b;
  logic hit_p;
  logic wave_nxt;

  assign hit_a = tick && (count_r == cfg.cmp_a);  // see R2
  assign hit_b = tick && cfg.has_b && (count_r == cfg.cmp_b);  // see R8
  // Period hits on the last count whose top bits match  // see R14
  assign hit_p = tick && (count_r[CNT_W-1 -: `TMR_PER_WIDTH] == cfg.cmp_p)
                 && (count_r[CNT_W-`TMR_PER_WIDTH-1:0] == '1);
  assign evt = '{match_a: hit_a, match_b: hit_b, match_p: hit_p};  // see R7

  function automatic logic apply(input timer_pkg::out_action_t act, input logic cur);
    case (act)
      timer_pkg::OUT_LOW:    apply = 1'b0;
      timer_pkg::OUT_HIGH:   apply = 1'b1;
      timer_pkg::OUT_TOGGLE: apply = ~cur;
      default:               apply = cur;
    endcase
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn || cnt_clear || !cfg.run) begin
      count_r <= '0;
    end else if (tick) begin
      if ((hit_p && cfg.clr_on_p) || (hit_a && cfg.clr_on_a)) begin
        count_r <= '0;  // see R2
      end else begin
        count_r <= count_r + 1'b1;  // see R15
      end
    end
  end

  always_comb begin
    wave_nxt = wave_r;
    if (cfg.mode == timer_pkg::MODE_PWM) begin
      // Edge-aligned: high from period start until compare A  // see R10
      if (hit_p) wave_nxt = 1'b1;
      if (hit_a) wave_nxt = 1'b0;
    end else if (cfg.mode == timer_pkg::MODE_COMPARE) begin
      if (hit_p) wave_nxt = apply(cfg.act_p, wave_nxt);  // see R9
      if (hit_b) wave_nxt = apply(cfg.act_b, wave_nxt);
      if (hit_a) wave_nxt = apply(cfg.act_a, wave_nxt);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg.run) wave_r <= 1'b0;
    else                      wave_r <= wave_nxt;
  end
endmodule

// *** tb/timer_core_asserts.sv ***
// Checker for the timer core: bus handshakes, response timing and pin enables.
// Assumes a single aclk domain; attached to timer_core by the bind at the foot.
`timescale 1ns/1ps
`include "timer_regs.svh"
module timer_core_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  timer_output_en_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence aw_take;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_take;
    s_axi_wvalid && s_axi_wready;
  endsequence

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  wr_resp_a: assert property ((aw_take and w_take) |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during data");
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == `TMR_AXI_SLVERR |->
    s_axi_rdata == 32'h0) else $error("error read carries data");
  pin_unused_a: assert property (timer_output_en_r[3:2] == 2'b11)
    else $error("unused pin driven");
endmodule

bind timer_core timer_core_asserts chk_u (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_output_en_r
);

// *** tb/ext_src.sv ***
// Model of the external clock source wired to both timers' clock pins.
// Assumes burst is called right after a rising aclk edge.
`timescale 1ns/1ps
module ext_src (
  input  wire logic  aclk,
  output logic [1:0] pin
);
  initial pin = 2'b00;
  // Two-cycle phases so an edge detector on either edge sees each one;
  // ends high, giving one more rising than falling edge
  task automatic burst(input int n);
    repeat (n) begin
      pin <= 2'b11;
      repeat (2) @(posedge aclk);
      pin <= 2'b00;
      repeat (2) @(posedge aclk);
    end
    pin <= 2'b11;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the timer core: registers, clock selects, matches, pins.
// Assumes ext_src drives the clock pins; the bench drives ticks and the bus.
`timescale 1ns/1ps
`include "timer_regs.svh"
module tb_top;
  localparam CT0 = `TMR_OFF_CTRL, CT1 = CT0 + `TMR_STRIDE;
  localparam CA0 = `TMR_OFF_CMPA, CA1 = CA0 + `TMR_STRIDE;
  localparam CB1 = `TMR_OFF_CMPB + `TMR_STRIDE, CP1 = `TMR_OFF_CMPP + `TMR_STRIDE;
  localparam CN0 = `TMR_OFF_COUNT, CN1 = CN0 + `TMR_STRIDE, OC0 = `TMR_OFF_OUTCFG;
  localparam ST = `TMR_OFF_STATUS, MK = `TMR_OFF_MASK;
  localparam PS = `TMR_OFF_PINSEL, PD = `TMR_OFF_PORTDATA;
  localparam int EXP [6] = '{16, 64, 4, 1, 64, 0};
  localparam logic [7:0] ACT [4] = '{8'h02, 8'h01, 8'h03, 8'h03};
  localparam logic [3:0] WAV = 4'b0101;
  logic        aclk, aresetn, sys_tick, hs_tick, tbc_tick, irq_r;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, external_timer_clock_pin;
  logic [7:0]  shared_func_out, timer_output_pin_r, timer_output_en_r;
  integer      seed, error_cnt, checked, c;

  timer_core dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_tick, .hs_tick, .tbc_tick,
    .external_timer_clock_pin, .shared_func_out, .timer_output_pin_r,
    .timer_output_en_r, .irq_r
  );
  ext_src src_u (.aclk, .pin(external_timer_clock_pin));

  always #12.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Ready is held back a random 0..3 cycles so the slave must hold its answer
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er = `TMR_AXI_OKAY);
    int n = 0;
    int dly;
    dly = $random(seed) & 3;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= dly == 0;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      n++;
      s_axi_bready <= n >= dly;
    end
    chk(s_axi_bresp, er);
  endtask

  task automatic rdr(input logic [31:0] a, input logic [1:0] er = `TMR_AXI_OKAY);
    int n = 0;
    int dly;
    dly = $random(seed) & 3;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= dly == 0;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      n++;
      s_axi_rready <= n >= dly;
    end
    rd = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask

  // All three strobes pulse together; the clock select decides which one counts
  task automatic tk(input int n);
    repeat (n) begin
      {sys_tick, hs_tick, tbc_tick} <= 3'b111;
      @(posedge aclk);
      {sys_tick, hs_tick, tbc_tick} <= 3'b000;
      @(posedge aclk);
    end
    repeat (3) @(posedge aclk);
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test;
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, sys_tick, hs_tick, tbc_tick} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    shared_func_out = 8'h00;
    seed = 32'h40be_0c41;
    error_cnt = 0;
    checked = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    shared_func_out <= 8'($random(seed));
    @(posedge aclk);
    rdr(PS);
    chk(rd, 8'h11);
    rdr(PD);
    chk(rd, 8'hFF);
    rdr(32'h80, `TMR_AXI_SLVERR);
    chk(rd, 8'h00);
    wr(32'h18, 8'h00, `TMR_AXI_SLVERR);
    for (int s = 0; s < 6; s++) begin
      wr(CT0, 8'h00);
      wr(CT0, 8'h10 | s);
      tk(64);
      rdr(CN0);
      chk(rd, EXP[s]);
    end
    wr(CT0, 8'h16);
    wr(CT1, 8'h1F);
    src_u.burst(5);
    rdr(CN0);
    chk(rd, 8'h06);
    rdr(CN1);
    chk(rd, 8'h05);
    rdr(ST);
    c = 1 + ($random(seed) & 31);
    wr(MK, 8'h01);
    wr(CA0, c);
    wr(CT0, 8'h00);
    wr(CT0, 8'h51);
    for (int m = 1; m >= 0; m--) begin
      tk(c + 1);
      chk(irq_r, m);
      rdr(CN0);
      chk(rd, 8'h00);
      rdr(ST);
      chk(rd, 8'h01);
      repeat (2) @(posedge aclk);
      chk(irq_r, 1'b0);
      wr(MK, 8'h00);
    end
    wr(CA1, 10'h3FF);
    wr(CB1, 10'h3FF);
    wr(CP1, 8'h07);
    wr(CT1, 8'h00);
    wr(CT1, 8'h11);
    tk(1030);
    rdr(CN1);
    chk(rd, 8'h06);
    rdr(ST);
    chk(rd, 8'h39);
    wr(PS, 8'h03);
    wr(PD, 8'hFE);
    wr(CA0, 8'h02);
    wr(CT0, 8'h00);
    wr(CT0, 8'h51);
    for (int i = 0; i < 4; i++) begin
      wr(OC0, ACT[i]);
      tk(3);
      chk(timer_output_pin_r[1:0], {WAV[i], ~WAV[i]});
    end
    chk(timer_output_en_r, 8'hFC);
    chk(timer_output_pin_r[7:2], shared_func_out[7:2]);
    wr(CT0, 8'h00);
    wr(CT0, 16'h0231);
    tk(128);
    chk(timer_output_pin_r[1], 1'b1);
    tk(3);
    chk(timer_output_pin_r[1], 1'b0);
    end_of_test;
  end
endmodule
